/* shared/kil_pkg.sv */
`default_nettype none
package kil_pkg;
	localparam int KIL_NPINS = 5;
	localparam logic [7:0] KIL_IDX_STATUS = 8'h1B;
	localparam logic [7:0] KIL_IDX_ENABLE = 8'h21;
	localparam logic [9:0] KIL_ADDR_STATUS = {KIL_IDX_STATUS, 2'b00};
	localparam logic [9:0] KIL_ADDR_ENABLE = {KIL_IDX_ENABLE, 2'b00};
	localparam int KIL_BIT_FLAG = 3;
	localparam int KIL_BIT_ACK = 2;
	localparam int KIL_BIT_MASK = 1;
	localparam int KIL_BIT_MODE = 0;
	localparam logic [7:0] KIL_RST_STATUS = 8'h00;
	localparam logic [7:0] KIL_RST_ENABLE = 8'h00;
	localparam logic [15:0] KIL_VEC_HI_ADDR = 16'hFFD2;
	localparam logic [15:0] KIL_VEC_LO_ADDR = 16'hFFD3;
	localparam logic [1:0] KIL_HTRANS_NONSEQ = 2'h2;
	typedef struct packed {
		logic [3:0] zero;
		logic flag;
		logic ack;
		logic mask;
		logic mode;
	} kil_status_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [9:0] addr;
	} kil_aphase_t;
endpackage : kil_pkg
`default_nettype wire

/* hdl/kil_keypad_latch.sv */
`default_nettype none
module kil_keypad_latch
	import kil_pkg::*;
#(
	parameter int NPINS = KIL_NPINS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [NPINS-1:0] key_pin_in,
	input wire logic vector_fetch,
	input wire logic break_state,
	input wire logic break_clear_enable,
	output logic [NPINS-1:0] key_pullup_en,
	output logic [NPINS-1:0] key_force_input,
	output logic key_irq,
	output logic [15:0] key_vector_addr
);
	if (NPINS != KIL_NPINS) begin : g_chk
		$error("kil_keypad_latch: pin count must be five");
	end

	logic [NPINS-1:0] sync1_q;
	logic [NPINS-1:0] sync2_q;
	logic [NPINS-1:0] key_pin_enables_q;
	logic key_irq_mask_q;
	logic key_sensitivity_select_q;
	logic latch_q;
	logic latch_d;
	logic any_low_q;
	logic ack_pend_q;
	kil_aphase_t aph_q;
	kil_status_t status_rd;
	logic any_low;
	logic fall;
	logic sw_ack;
	logic ack;
	logic set_ev;
	logic clr_ev;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// two flops before anything looks at the pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= '1;
			sync2_q <= '1;
		end else if (ce) begin
			sync1_q <= key_pin_in;
			sync2_q <= sync1_q;
		end
	end

	assign any_low = |(~sync2_q & key_pin_enables_q);
	assign fall = any_low & ~any_low_q;
	assign sw_ack = aph_q.valid & aph_q.write & (aph_q.addr == KIL_ADDR_STATUS)
		& hwdata[KIL_BIT_ACK];
	// break protection only guards the software path
	assign ack = vector_fetch
		| (sw_ack & ~(break_state & ~break_clear_enable));
	assign set_ev = key_sensitivity_select_q ? any_low : fall;
	assign clr_ev = key_sensitivity_select_q ? ((ack | ack_pend_q) & ~any_low)
		: ack;
	assign latch_d = set_ev | (latch_q & ~clr_ev);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_q <= 1'b0;
			any_low_q <= 1'b0;
		end else if (ce) begin
			latch_q <= latch_d;
			any_low_q <= any_low;
		end
	end

	// ack taken while pins still low is remembered until they rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_pend_q <= 1'b0;
		end else if (ce) begin
			if (!latch_d || fall)
				ack_pend_q <= 1'b0;
			else if (ack)
				ack_pend_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_q <= '0;
		end else if (ce && hready) begin
			aph_q.valid <= hsel & (htrans == KIL_HTRANS_NONSEQ);
			aph_q.write <= hwrite;
			aph_q.addr <= haddr[9:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_irq_mask_q <= KIL_RST_STATUS[KIL_BIT_MASK];
			key_sensitivity_select_q <= KIL_RST_STATUS[KIL_BIT_MODE];
			key_pin_enables_q <= KIL_RST_ENABLE[NPINS-1:0];
		end else if (ce && aph_q.valid && aph_q.write) begin
			if (aph_q.addr == KIL_ADDR_STATUS) begin
				key_irq_mask_q <= hwdata[KIL_BIT_MASK];
				key_sensitivity_select_q <= hwdata[KIL_BIT_MODE];
			end
			if (aph_q.addr == KIL_ADDR_ENABLE)
				key_pin_enables_q <= hwdata[NPINS-1:0];
		end
	end

	always_comb begin
		status_rd = '0;
		status_rd.flag = latch_q;
		status_rd.ack = 1'b0;
		status_rd.mask = key_irq_mask_q;
		status_rd.mode = key_sensitivity_select_q;
	end

	// read data captured in the address phase: zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (ce && hready) begin
			hrdata <= '0;
			if (hsel && htrans == KIL_HTRANS_NONSEQ && !hwrite) begin
				if (haddr[9:0] == KIL_ADDR_STATUS)
					hrdata <= {24'h000000, status_rd};
				else if (haddr[9:0] == KIL_ADDR_ENABLE)
					hrdata <= {{(32 - NPINS){1'b0}}, key_pin_enables_q};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_irq <= 1'b0;
			key_pullup_en <= '0;
			key_force_input <= '0;
			key_vector_addr <= KIL_VEC_HI_ADDR;
		end else if (ce) begin
			key_irq <= latch_d & ~key_irq_mask_q;
			key_pullup_en <= key_pin_enables_q;
			key_force_input <= key_pin_enables_q;
			key_vector_addr <= KIL_VEC_HI_ADDR;
		end
	end

	property p_edge_set;
		@(posedge hclk) disable iff (!hresetn)
		ce && fall && !key_sensitivity_select_q |=> latch_q;
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("edge did not set latch");

	property p_no_set_when_low;
		@(posedge hclk) disable iff (!hresetn)
		ce && !key_sensitivity_select_q && !latch_q && any_low_q && !fall |=> !latch_q;
	endproperty
	a_no_set_when_low: assert property (p_no_set_when_low) else $error("set while already low");

	property p_level_hold;
		@(posedge hclk) disable iff (!hresetn)
		ce && key_sensitivity_select_q && any_low |=> latch_q;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level mode dropped latch");

	property p_edge_clear;
		@(posedge hclk) disable iff (!hresetn)
		ce && !key_sensitivity_select_q && ack && !fall |=> !latch_q;
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("ack did not clear");

	property p_break_protect;
		@(posedge hclk) disable iff (!hresetn)
		ce && break_state && !break_clear_enable && !vector_fetch && latch_q
			&& !key_sensitivity_select_q |=> latch_q;
	endproperty
	a_break_protect: assert property (p_break_protect) else $error("latch cleared in break");

	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		ce ##1 ce |-> key_irq == ($past(latch_d) && !$past(key_irq_mask_q));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not latch and not mask");

	property p_flag_read;
		@(posedge hclk) disable iff (!hresetn)
		ce && hready && hsel && htrans == KIL_HTRANS_NONSEQ && !hwrite
			&& haddr[9:0] == KIL_ADDR_STATUS
			|=> hrdata[7:4] == 4'h0 && hrdata[KIL_BIT_ACK] == 1'b0
			&& hrdata[KIL_BIT_FLAG] == $past(latch_q);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("status read wrong");

	property p_pullup;
		@(posedge hclk) disable iff (!hresetn)
		ce ##1 ce |-> key_pullup_en == $past(key_pin_enables_q);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up not following enable");

	property p_sync;
		@(posedge hclk) disable iff (!hresetn)
		ce ##1 ce |-> sync2_q == $past(sync1_q);
	endproperty
	a_sync: assert property (p_sync) else $error("sync chain broken");

	c_edge: cover property (@(posedge hclk) disable iff (!hresetn) fall ##1 latch_q);
	c_level_ack: cover property (@(posedge hclk) disable iff (!hresetn)
		key_sensitivity_select_q && ack && any_low ##[1:20] !latch_q);
	c_break: cover property (@(posedge hclk) disable iff (!hresetn)
		break_state && sw_ack && latch_q);
endmodule : kil_keypad_latch
`default_nettype wire

/* test/kil_keypad_switches.sv */
`default_nettype none
// released keys rely on board pull-ups, so an idle pin reads high
module kil_keypad_switches (
	input wire logic [4:0] pressed,
	output logic [4:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pin_level = ~pressed;
endmodule : kil_keypad_switches
`default_nettype wire

/* test/keypad_interrupt_latch_test.sv */
`default_nettype none
module keypad_interrupt_latch_test;
	import kil_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, vf, brk, bce, key_irq;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [4:0] press, pins, key_pullup_en, key_force_input;
	logic [15:0] key_vector_addr;
	int bad_count = 0;
	int check_count = 0;
	kil_keypad_switches sw (.pressed(press), .pin_level(pins));
	kil_keypad_latch dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.key_pin_in(pins), .vector_fetch(vf), .break_state(brk),
		.break_clear_enable(bce), .key_pullup_en(key_pullup_en),
		.key_force_input(key_force_input), .key_irq(key_irq),
		.key_vector_addr(key_vector_addr));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	task automatic give_verdict;
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one single transfer; hready stalls are honoured even though none are expected
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {22'h000000, a};
		hwrite <= w;
		htrans <= KIL_HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : bus
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		chk(rv, e);
	endtask : rd
	task automatic ws(input logic [31:0] d);
		bus(1'b1, KIL_ADDR_STATUS, d);
	endtask : ws
	task automatic st(input logic [31:0] e);
		rd(KIL_ADDR_STATUS, e);
	endtask : st
	// two sync stages then the latch edge, plus one cycle of margin
	task automatic w4;
		repeat (4) @(posedge hclk);
	endtask : w4
	task automatic hit(input logic [4:0] p);
		press <= p;
		w4();
	endtask : hit
	initial begin
		repeat (5000) @(posedge hclk);
		bad_count++;
		give_verdict();
	end
	initial begin
		{hresetn, hsel, hwrite, vf, brk, bce, htrans, haddr, hwdata, press} = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		st(32'h00000000);
		rd(KIL_ADDR_ENABLE, 32'h00000000);
		chk(32'(key_vector_addr), 32'h0000FFD2);
		rd(10'h3FC, 32'h00000000);
		bus(1'b1, KIL_ADDR_ENABLE, 32'h0000001F);
		rd(KIL_ADDR_ENABLE, 32'h0000001F);
		chk(32'(key_pullup_en), 32'h0000001F);
		chk(32'(key_force_input), 32'h0000001F);
		hit(5'h01);
		st(32'h00000008);
		chk(32'(key_irq), 32'h00000001);
		hit(5'h03);
		ws(32'h00000004);
		st(32'h00000000);
		hit(5'h07);
		st(32'h00000000);
		hit(5'h00);
		hit(5'h10);
		st(32'h00000008);
		vf <= 1'b1;
		@(posedge hclk);
		vf <= 1'b0;
		@(posedge hclk);
		st(32'h00000000);
		ws(32'h00000002);
		hit(5'h00);
		hit(5'h01);
		st(32'h0000000A);
		chk(32'(key_irq), 32'h00000000);
		ws(32'h00000001);
		st(32'h00000009);
		ws(32'h00000005);
		st(32'h00000009);
		hit(5'h00);
		st(32'h00000001);
		ws(32'h00000000);
		hit(5'h01);
		st(32'h00000008);
		brk <= 1'b1;
		ws(32'h00000004);
		w4();
		st(32'h00000008);
		bce <= 1'b1;
		ws(32'h00000004);
		st(32'h00000000);
		brk <= 1'b0;
		w4();
		st(32'h00000000);
		ws(32'h00000001);
		w4();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		st(32'h00000000);
		chk(32'(key_irq), 32'h00000000);
		give_verdict();
	end
endmodule : keypad_interrupt_latch_test
`default_nettype wire
